// [design/aba_pkg.sv]
// aba_pkg: register map, field layout, operation codes and carrier types
// for the host-side controller of the byte-serial block accelerator.
// assumes: device registers are reached over a simple byte-wide port.
package aba_pkg;

   // device register offsets
   localparam logic [1:0] ABA_OFS_CONTROL = 2'h0;
   localparam logic [1:0] ABA_OFS_STATUS  = 2'h1;
   localparam logic [1:0] ABA_OFS_INPUT   = 2'h2;
   localparam logic [1:0] ABA_OFS_OUTPUT  = 2'h3;

   // control_reg field positions
   localparam int ABA_CTL_DMA_EN   = 7;
   localparam int ABA_CTL_ERR_IE   = 6;
   localparam int ABA_CTL_DONE_IE  = 5;
   localparam int ABA_CTL_ERR_CLR  = 4;
   localparam int ABA_CTL_DONE_CLR = 3;
   localparam int ABA_CTL_OP_LSB   = 1;
   localparam int ABA_CTL_EN       = 0;

   // status_reg field positions
   localparam int ABA_ST_WR_ERR = 2;
   localparam int ABA_ST_RD_ERR = 1;
   localparam int ABA_ST_DONE   = 0;

   // operation_select codes
   localparam logic [1:0] ABA_OP_ENCRYPT = 2'h0;
   localparam logic [1:0] ABA_OP_KEYDER  = 2'h1;
   localparam logic [1:0] ABA_OP_DECRYPT = 2'h2;
   localparam logic [1:0] ABA_OP_KD_DEC  = 2'h3;

   // byte counts per block
   localparam logic [5:0] ABA_IN_BYTES_FULL  = 6'h20;
   localparam logic [5:0] ABA_IN_BYTES_KEY   = 6'h10;
   localparam logic [5:0] ABA_OUT_BYTES      = 6'h10;

   // fifo geometry and reset values
   localparam int         ABA_FIFO_DEPTH = 16;
   localparam logic [7:0] ABA_CTL_RESET  = 8'h00;

   // user order to the controller
   typedef struct packed {
      logic [1:0] op;
      logic       dma;
      logic       done_ie;
      logic       err_ie;
   } aba_cfg_t;

   // device register access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [1:0] addr;
      logic [7:0] wdata;
   } aba_bus_t;

   function automatic logic [5:0] aba_in_count(input logic [1:0] op);
      aba_in_count = (op == ABA_OP_KEYDER) ? ABA_IN_BYTES_KEY : ABA_IN_BYTES_FULL;
   endfunction

endpackage

// [design/aba_fifo_mem.sv]
// aba_fifo_mem: small dual-port storage with registered read data.
// assumes: one writer and one reader on the same clock.
`timescale 1ns/1ps
module aba_fifo_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             sys_clk_i,
   input  wire logic             we_i,
   input  wire logic [AW-1:0]    waddr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   input  wire logic [AW-1:0]    raddr_i,
   output logic      [WIDTH-1:0] rdata_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge sys_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule

// [design/aba_fifo.sv]
// aba_fifo: first-word-fall-through buffer with valid/ready on both sides.
// assumes: synchronous to sys_clk_i; storage in aba_fifo_mem.
`timescale 1ns/1ps
module aba_fifo
   import aba_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = ABA_FIFO_DEPTH
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rstn_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wptr;
      logic [AW:0] rptr;
      logic        oval;
   } aba_fifo_state_t;

   // one memory slot stays free: it still holds the word in the output register
   localparam logic [AW:0] MEM_SLOTS = (AW+1)'(DEPTH - 1);

   aba_fifo_state_t s_reg, s_next;
   logic [AW:0]     count;
   logic [AW-1:0]   rd_addr;
   logic            push, pop, load;

   assign count       = s_reg.wptr - s_reg.rptr;
   assign in_ready_o  = (count < MEM_SLOTS);
   assign push        = in_valid_i && in_ready_o;
   assign out_valid_o = s_reg.oval;
   assign pop         = s_reg.oval && out_ready_i;
   // memory word moves to the output register when it is empty or drained
   assign load        = (count != '0) && (!s_reg.oval || pop);
   // re-read the shown word until the next load so the output holds still
   assign rd_addr     = load ? s_reg.rptr[AW-1:0] : s_reg.rptr[AW-1:0] - 1'b1;

   aba_fifo_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
      .sys_clk_i (sys_clk_i),
      .we_i      (push),
      .waddr_i   (s_reg.wptr[AW-1:0]),
      .wdata_i   (in_data_i),
      .raddr_i   (rd_addr),
      .rdata_o   (out_data_o)
   );

   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.wptr = s_reg.wptr + 1'b1;
      end
      if (load) begin
         s_next.rptr = s_reg.rptr + 1'b1;
         s_next.oval = 1'b1;
      end else if (pop) begin
         s_next.oval = 1'b0;
      end
      if (flush_i) begin
         s_next = '0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

// [design/aba_host.sv]
// aba_host: controller that drives the block accelerator over its
// byte register port: programs control_reg, streams input bytes, waits for
// completion, reads 16 result bytes into a fifo and, in cpu mode, clears the flag.
// assumes: device answers a read with rdata valid one cycle after rd.
`timescale 1ns/1ps
module aba_host
   import aba_pkg::*;
#(
   parameter int FIFO_DEPTH = ABA_FIFO_DEPTH
) (
   input  wire logic       sys_clk_i,
   input  wire logic       rstn_i,
   // user orders
   input  wire logic       cfg_valid_i,
   input  wire aba_cfg_t   cfg_i,
   output logic            cfg_ready_o,
   input  wire logic       stop_i,
   input  wire logic       in_valid_i,
   input  wire logic [7:0] in_data_i,
   output logic            in_ready_o,
   output logic            out_valid_o,
   output logic [7:0]      out_data_o,
   input  wire logic       out_ready_i,
   output logic            err_o,
   output logic            busy_o,
   // device register port
   output logic            dev_wr_o,
   output logic            dev_rd_o,
   output logic [1:0]      dev_addr_o,
   output logic [7:0]      dev_wdata_o,
   input  wire logic [7:0] dev_rdata_i,
   input  wire logic       dev_irq_i,
   input  wire logic       dev_in_req_i,
   input  wire logic       dev_out_req_i
);
   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0000,
      ST_DISABLE = 4'b0001,
      ST_PROG    = 4'b0010,
      ST_ENABLE  = 4'b0011,
      ST_WRITE   = 4'b0100,
      ST_POLL    = 4'b0101,
      ST_POLLW   = 4'b0110,
      ST_READ    = 4'b0111,
      ST_READW   = 4'b1000,
      ST_CLEAR   = 4'b1001,
      ST_ERRCLR  = 4'b1010,
      ST_VERIFY  = 4'b1011,
      ST_VERIFYW = 4'b1100,
      ST_AUDIT   = 4'b1101,
      ST_AUDITW  = 4'b1110
   } aba_state_t;

   typedef struct packed {
      aba_state_t st;
      aba_cfg_t   cfg;
      logic [5:0] cnt;
      aba_bus_t   bus;
      logic       in_ready;
      logic       err;
      logic       busy;
      logic       rd_pend;
   } aba_host_state_t;

   aba_host_state_t s_reg, s_next;
   logic            f_valid, f_ready, f_in_valid;
   logic [7:0]      f_data;

   // control_reg image with block_enable and optional clear strobes
   function automatic logic [7:0] ctl_word(input aba_cfg_t c, input logic en,
                                           input logic done_clr, input logic err_clr);
      logic [7:0] w;
      w                        = ABA_CTL_RESET;
      w[ABA_CTL_DMA_EN]        = c.dma;
      w[ABA_CTL_ERR_IE]        = c.err_ie;
      w[ABA_CTL_DONE_IE]       = c.done_ie;
      w[ABA_CTL_ERR_CLR]       = err_clr;
      w[ABA_CTL_DONE_CLR]      = done_clr;
      w[ABA_CTL_OP_LSB+:2]     = c.op;
      w[ABA_CTL_EN]            = en;
      return w;
   endfunction

   // one-cycle register read strobe
   function automatic aba_bus_t bus_read(input logic [1:0] addr);
      aba_bus_t b;
      b      = '0;
      b.rd   = 1'b1;
      b.addr = addr;
      return b;
   endfunction

   // one-cycle register write strobe
   function automatic aba_bus_t bus_write(input logic [1:0] addr, input logic [7:0] data);
      aba_bus_t b;
      b       = '0;
      b.wr    = 1'b1;
      b.addr  = addr;
      b.wdata = data;
      return b;
   endfunction

   // either error flag set in a status word
   function automatic logic status_error(input logic [7:0] s);
      return s[ABA_ST_RD_ERR] || s[ABA_ST_WR_ERR];
   endfunction

   // result bytes land in the fifo; its ready stalls further reads
   assign f_in_valid = s_reg.rd_pend;

   aba_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .rstn_i      (rstn_i),
      .flush_i     (1'b0),
      .in_valid_i  (f_in_valid),
      .in_ready_o  (f_ready),
      .in_data_i   (dev_rdata_i),
      .out_valid_o (f_valid),
      .out_ready_i (out_ready_i),
      .out_data_o  (f_data)
   );

   always_comb begin
      s_next          = s_reg;
      s_next.bus.wr   = 1'b0;
      s_next.bus.rd   = 1'b0;
      s_next.in_ready = 1'b0;
      s_next.rd_pend  = 1'b0;
      case (s_reg.st)
         ST_IDLE: begin
            if (cfg_valid_i) begin
               s_next.cfg  = cfg_i;
               s_next.busy = 1'b1;
               s_next.err  = 1'b0;
               s_next.st   = ST_DISABLE;
            end
         end
         ST_DISABLE: begin
            // block_enable dropped first, done_flag and both error flags cleared
            s_next.bus = '{wr: 1'b1, rd: 1'b0, addr: ABA_OFS_CONTROL,
                           wdata: ctl_word(s_reg.cfg, 1'b0, 1'b1, 1'b1)};
            s_next.st  = ST_PROG;
         end
         ST_PROG: begin
            // operation and irq enables while still disabled
            s_next.bus = '{wr: 1'b1, rd: 1'b0, addr: ABA_OFS_CONTROL,
                           wdata: ctl_word(s_reg.cfg, 1'b0, 1'b0, 1'b0)};
            s_next.st  = ST_ENABLE;
         end
         ST_ENABLE: begin
            s_next.bus = '{wr: 1'b1, rd: 1'b0, addr: ABA_OFS_CONTROL,
                           wdata: ctl_word(s_reg.cfg, 1'b1, 1'b0, 1'b0)};
            // input counter restarts with every fresh input phase
            s_next.cnt = '0;
            s_next.st  = ST_VERIFY;
         end
         ST_WRITE: begin
            // one byte per user handshake, any gap allowed
            if (stop_i) begin
               s_next.st = ST_IDLE;
               s_next.bus = '{wr: 1'b1, rd: 1'b0, addr: ABA_OFS_CONTROL,
                              wdata: ctl_word(s_reg.cfg, 1'b0, 1'b0, 1'b0)};
               s_next.busy = 1'b0;
            end else if (s_reg.cnt == aba_in_count(s_reg.cfg.op)) begin
               s_next.cnt = '0;
               s_next.st  = ST_POLL;
            end else if (s_reg.in_ready && in_valid_i) begin
               s_next.bus = bus_write(ABA_OFS_INPUT, in_data_i);
               s_next.cnt = s_reg.cnt + 6'h01;
            end else begin
               // ready pulses every other cycle and never beside a pending write
               s_next.in_ready = !s_reg.bus.wr && !s_reg.in_ready &&
                                 (!s_reg.cfg.dma || dev_in_req_i);
            end
         end
         ST_POLL: begin
            if (s_reg.cfg.dma) begin
               s_next.st = ST_READ;
            end else if (!s_reg.cfg.done_ie || dev_irq_i) begin
               // with the done interrupt on, status is read only once it fires
               s_next.bus = bus_read(ABA_OFS_STATUS);
               s_next.st  = ST_POLLW;
            end
         end
         ST_POLLW: begin
            // device answers status one cycle after the read strobe
            if (!s_reg.bus.rd) begin
               if (status_error(dev_rdata_i)) begin
                  s_next.err = 1'b1;
               end
               s_next.st = dev_rdata_i[ABA_ST_DONE] ? ST_READ : ST_POLL;
            end
         end
         ST_READ: begin
            // one read in flight; fifo room is checked before each strobe
            if (s_reg.cnt == ABA_OUT_BYTES) begin
               s_next.cnt = '0;
               s_next.st  = s_reg.cfg.dma ? ST_ERRCLR : ST_AUDIT;
            end else if (f_ready && !s_reg.rd_pend && !s_reg.bus.rd &&
                         (!s_reg.cfg.dma || dev_out_req_i)) begin
               s_next.bus = bus_read(ABA_OFS_OUTPUT);
               s_next.st  = ST_READW;
            end
         end
         ST_READW: begin
            s_next.rd_pend = 1'b1;
            s_next.cnt     = s_reg.cnt + 6'h01;
            s_next.st      = ST_READ;
         end
         ST_VERIFY: begin
            // read control back: enables and operation stick, clears read as zero
            s_next.bus = bus_read(ABA_OFS_CONTROL);
            s_next.st  = ST_VERIFYW;
         end
         ST_VERIFYW: begin
            if (!s_reg.bus.rd) begin
               if (dev_rdata_i != ctl_word(s_reg.cfg, 1'b1, 1'b0, 1'b0)) begin
                  s_next.err = 1'b1;
               end
               s_next.st = ST_WRITE;
            end
         end
         ST_AUDIT: begin
            // status once more after the result: a read error shows up here
            s_next.bus = bus_read(ABA_OFS_STATUS);
            s_next.st  = ST_AUDITW;
         end
         ST_AUDITW: begin
            if (!s_reg.bus.rd) begin
               if (status_error(dev_rdata_i)) begin
                  s_next.err = 1'b1;
               end
               s_next.st = ST_CLEAR;
            end
         end
         ST_CLEAR: begin
            s_next.bus = bus_write(ABA_OFS_CONTROL, ctl_word(s_reg.cfg, 1'b1, 1'b1, 1'b0));
            s_next.st  = ST_ERRCLR;
         end
         ST_ERRCLR: begin
            // error clear only once err is set, by a status read that saw a flag or by a control readback mismatch
            if (s_reg.err) begin
               s_next.bus = '{wr: 1'b1, rd: 1'b0, addr: ABA_OFS_CONTROL,
                              wdata: ctl_word(s_reg.cfg, 1'b1, 1'b0, 1'b1)};
            end
            s_next.st = ST_WRITE;
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // every output below is a register bit except cfg_ready_o, which is decoded from the state
   assign cfg_ready_o = (s_reg.st == ST_IDLE);
   assign in_ready_o  = s_reg.in_ready;
   assign out_valid_o = f_valid;
   assign out_data_o  = f_data;
   assign err_o       = s_reg.err;
   assign busy_o      = s_reg.busy;
   assign dev_wr_o    = s_reg.bus.wr;
   assign dev_rd_o    = s_reg.bus.rd;
   assign dev_addr_o  = s_reg.bus.addr;
   assign dev_wdata_o = s_reg.bus.wdata;
endmodule

// [verification/aba_dev_model.sv]
// aba_dev_model: behavioural model of the byte-serial block accelerator.
// assumes: register port with read data one cycle after the read strobe.
`timescale 1ns/1ps
module aba_dev_model #(
   parameter int CYC_ENC = 892,
   parameter int CYC_KD  = 320,
   parameter int CYC_KDD = 1228
) (
   input  wire logic       sys_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   input  wire logic [1:0] addr_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] rdata_o,
   output logic            irq_o,
   output logic            in_req_o,
   output logic            out_req_o
);
   logic [7:0] ctl;
   logic [7:0] mem [16];
   logic [2:0] st;
   logic [1:0] ph;
   logic [5:0] icnt;
   logic [5:0] ocnt;
   int         cyc;
   int         lim;
   wire        en   = ctl[0];
   wire  [5:0] need = (ctl[2:1] == 2'h1) ? 6'h10 : 6'h20;
   assign lim = (ctl[2:1] == 2'h1) ? CYC_KD : (ctl[2:1] == 2'h3) ? CYC_KDD : CYC_ENC;
   assign in_req_o  = en && ctl[7] && ph == 2'h0;
   assign out_req_o = en && ctl[7] && ph == 2'h2;
   assign irq_o = (st[0] && ctl[5]) || ((|st[2:1]) && ctl[6]);
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctl <= 8'h00;
         st <= 3'h0;
         ph <= 2'h0;
         icnt <= 6'h00;
         ocnt <= 6'h00;
         cyc <= 0;
         rdata_o <= 8'h00;
      end else begin
         if (ph == 2'h1) begin
            cyc <= cyc + 1;
            if (cyc == lim - 1) begin
               st[0] <= 1'h1;
               ph <= 2'h2;
            end
         end
         if (wr_i && addr_i == 2'h0) begin
            ctl <= {wdata_i[7:5], 2'h0, wdata_i[2:0]};
            if (wdata_i[3]) st[0] <= 1'h0;
            if (wdata_i[4]) st[2:1] <= 2'h0;
         end
         if (wr_i && addr_i == 2'h2 && en) begin
            if (ph == 2'h0) begin
               mem[icnt[3:0]] <= wdata_i;
               icnt <= icnt + 6'h01;
               if (icnt == need - 6'h01) ph <= 2'h1;
               if (icnt == need - 6'h01) cyc <= 0;
            end else st[2] <= 1'h1;
         end
         if (rd_i) rdata_o <= (addr_i == 2'h3) ? ~mem[ocnt[3:0]] : (addr_i == 2'h1) ?
                               {5'h00, st} : (addr_i == 2'h0) ? ctl : 8'h00;
         if (rd_i && addr_i == 2'h3 && en) begin
            if (ph == 2'h2) begin
               ocnt <= ocnt + 6'h01;
               if (ocnt == 6'h0F) ph <= 2'h0;
               if (ocnt == 6'h0F) icnt <= 6'h00;
               if (ocnt == 6'h0F) ocnt <= 6'h00;
            end else st[1] <= 1'h1;
         end
         if (!en) begin
            ph <= 2'h0;
            icnt <= 6'h00;
            ocnt <= 6'h00;
         end
      end
   end
endmodule

// [verification/aba_host_chk.sv]
// aba_host_chk: port-level properties of the accelerator host controller.
// assumes: bound into aba_host; one clock domain.
`timescale 1ns/1ps
module aba_host_chk
   import aba_pkg::*;
(
   input wire logic       sys_clk_i,
   input wire logic       rstn_i,
   input wire logic       cfg_valid_i,
   input wire aba_cfg_t   cfg_i,
   input wire logic       cfg_ready_o,
   input wire logic       in_valid_i,
   input wire logic [7:0] in_data_i,
   input wire logic       in_ready_o,
   input wire logic       out_valid_o,
   input wire logic       busy_o,
   input wire logic       dev_wr_o,
   input wire logic       dev_rd_o,
   input wire logic [1:0] dev_addr_o,
   input wire logic [7:0] dev_wdata_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   wire take   = cfg_valid_i && cfg_ready_o;
   wire ctl_wr = dev_wr_o && dev_addr_o == ABA_OFS_CONTROL;
   wire in_wr  = dev_wr_o && dev_addr_o == ABA_OFS_INPUT;
   a_strobe_excl: assert property (!(dev_wr_o && dev_rd_o))
      else $error("read and write strobes together");
   a_disable_first: assert property (take |=> ##1 ctl_wr && !dev_wdata_o[0])
      else $error("first control write leaves block enabled");
   a_program_op: assert property (take |=> ##2 ctl_wr && !dev_wdata_o[0] &&
      dev_wdata_o[2:1] == $past(cfg_i.op, 3)) else $error("operation code wrong");
   a_enable_last: assert property (take |=> ##3 ctl_wr && dev_wdata_o[0] &&
      dev_wdata_o[7:5] == $past({cfg_i.dma, cfg_i.err_ie, cfg_i.done_ie}, 4))
      else $error("enable write wrong");
   a_busy_taken: assert property (take |=> busy_o && !cfg_ready_o)
      else $error("order not taken");
   a_in_source: assert property (in_wr |-> $past(in_valid_i && in_ready_o))
      else $error("input write without a taken byte");
   a_in_data: assert property (in_wr |-> dev_wdata_o == $past(in_data_i))
      else $error("input byte altered");
   a_ready_pulse: assert property (in_ready_o |=> !in_ready_o)
      else $error("input ready held");
   a_idle_refuse: assert property (cfg_ready_o |-> !in_ready_o && !in_wr)
      else $error("input taken while idle");
   a_out_lands: assert property (dev_rd_o && dev_addr_o == ABA_OFS_OUTPUT |->
      ##[1:4] out_valid_o) else $error("result byte lost");
   cover property (take);
   cover property (in_wr);
   cover property (dev_rd_o && dev_addr_o == ABA_OFS_OUTPUT);
endmodule
bind aba_host aba_host_chk u_aba_host_chk (.*);

// [verification/aba_host_tb.sv]
// aba_host_tb: drives the host controller against the device model.
// assumes: aba_host_chk is bound; device model answers reads in one cycle.
`timescale 1ns/1ps
module aba_host_tb
   import aba_pkg::*;
;
   logic       sys_clk_i, rstn_i, cfg_valid_i, stop_i, in_valid_i, out_ready_i;
   logic       cfg_ready_o, in_ready_o, out_valid_o, err_o, busy_o, dev_wr_o, dev_rd_o;
   logic       irq, in_req, out_req;
   aba_cfg_t   cfg_i;
   logic [1:0] dev_addr_o;
   logic [7:0] in_data_i, dev_wdata_o, rdata, out_data_o;
   logic [7:0] sent [32];
   int         failures = 0;
   int         compares = 0;
   aba_host u_aba_host (.*, .dev_rdata_i(rdata), .dev_irq_i(irq), .dev_in_req_i(in_req),
                        .dev_out_req_i(out_req));
   aba_dev_model u_aba_dev_model (.sys_clk_i, .rstn_i, .wr_i(dev_wr_o), .rd_i(dev_rd_o),
      .addr_i(dev_addr_o), .wdata_i(dev_wdata_o), .rdata_o(rdata), .irq_o(irq),
      .in_req_o(in_req), .out_req_o(out_req));
   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic hang();
      failures++;
      $display("ERROR %0t: wait timed out", $time);
      test_done();
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge sys_clk_i);
      #1;
   endtask
   task automatic order(input logic [1:0] op, input logic dma);
      int k;
      k = 0;
      while (!cfg_ready_o && k < 50) begin tick(); k++; end
      if (k == 50) hang();
      cfg_i = '{op, dma, 1'h1, 1'h1};
      cfg_valid_i = 1'h1;
      tick();
      cfg_valid_i = 1'h0;
   endtask
   task automatic send(input int n, input logic [7:0] seed);
      int k;
      for (int i = 0; i < n; i++) begin
         sent[i] = seed + 8'(i * 29);
         in_data_i = sent[i];
         in_valid_i = 1'h1;
         k = 0;
         while (!in_ready_o && k < 3000) begin tick(); k++; end
         if (k == 3000) hang();
         tick();
      end
      in_valid_i = 1'h0;
   endtask
   task automatic recv(input int n, input int stall);
      int k;
      repeat (stall) tick();
      out_ready_i = 1'h1;
      for (int i = 0; i < 16; i++) begin
         k = 0;
         while (!out_valid_o && k < 3000) begin tick(); k++; end
         if (k == 3000) hang();
         check(out_data_o, ~sent[n - 16 + i]);
         tick();
      end
      out_ready_i = 1'h0;
   endtask
   task automatic halt(input string name);
      int k;
      stop_i = 1'h1;
      k = 0;
      while (!cfg_ready_o && k < 3000) begin tick(); k++; end
      if (k == 3000) hang();
      stop_i = 1'h0;
      check({7'h00, err_o}, 8'h00);
      $display("test %0s finished", name);
   endtask
   initial begin
      sys_clk_i = 1'h0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      int nb;
      rstn_i = 1'h0;
      cfg_valid_i = 1'h0;
      cfg_i = '0;
      stop_i = 1'h0;
      in_valid_i = 1'h0;
      in_data_i = 8'h00;
      out_ready_i = 1'h0;
      repeat (20) @(posedge sys_clk_i);
      #1 rstn_i = 1'h1;
      for (int op = 0; op < 4; op++) begin
         nb = (op == 1) ? 16 : 32;
         order(2'(op), 1'h0);
         send(nb, 8'(op * 64));
         recv(nb, op * 10);
         send(nb, 8'h33);
         check({7'h00, u_aba_dev_model.st[0]}, 8'h00);
         recv(nb, 0);
         halt("cpu mode");
      end
      order(ABA_OP_ENCRYPT, 1'h1);
      send(32, 8'h5A);
      recv(32, 40);
      send(32, 8'hC3);
      recv(32, 0);
      halt("dma mode");
      order(ABA_OP_KEYDER, 1'h0);
      send(5, 8'h71);
      check({7'h00, u_aba_dev_model.st[0]}, 8'h00);
      halt("abort");
      order(ABA_OP_ENCRYPT, 1'h0);
      send(32, 8'h0F);
      recv(32, 0);
      halt("restart");
      test_done();
   end
endmodule
